// ### rtl/sfsp_regs.vh
// Constants for the serial flash status, protect and reset block
`ifndef SFSP_REGS_VH
`define SFSP_REGS_VH

// Core clock rate
`define SFSP_CLK_MHZ        250

// Status byte layout
`define SFSP_STAT_READY_BIT 7
`define SFSP_STAT_COMP_BIT  6
`define SFSP_STAT_DENS_MSB  5
`define SFSP_STAT_DENS_LSB  3
`define SFSP_STAT_RSVD      3'h0
`define SFSP_COMP_RESET     1'b0

// Command framing
`define SFSP_OP_STATUS_READ 8'h57
`define SFSP_CMD_BITS       6'd32
`define SFSP_PA_MSB         20
`define SFSP_PA_LSB         9
`define SFSP_PROT_PAGE_HI   4'h0

// Opcodes of the self-timed operations
`define SFSP_OP_XFR_B1      8'h53
`define SFSP_OP_XFR_B2      8'h55
`define SFSP_OP_CMP_B1      8'h60
`define SFSP_OP_CMP_B2      8'h61
`define SFSP_OP_EPRG_B1     8'h83
`define SFSP_OP_EPRG_B2     8'h86
`define SFSP_OP_PRG_B1      8'h88
`define SFSP_OP_PRG_B2      8'h89
`define SFSP_OP_MPRG_B1     8'h82
`define SFSP_OP_MPRG_B2     8'h85
`define SFSP_OP_RWR_B1      8'h58
`define SFSP_OP_RWR_B2      8'h59

// Operation kinds
`define SFSP_KIND_NONE      3'd0
`define SFSP_KIND_XFR       3'd1
`define SFSP_KIND_CMP       3'd2
`define SFSP_KIND_EPRG      3'd3
`define SFSP_KIND_PRG       3'd4
`define SFSP_KIND_RWR       3'd5

// Timing figures in their own units
`define SFSP_T_XFR_TYP_US   80
`define SFSP_T_XFR_MAX_US   150
`define SFSP_T_EP_TYP_MS    10
`define SFSP_T_EP_MAX_MS    20
`define SFSP_T_P_TYP_MS     7
`define SFSP_T_CSB_MAX_NS   200
`define SFSP_T_CS_MIN_NS    250
`define SFSP_T_PWRUP_MS     20

`endif

// ### rtl/sfsp_optimer.v
// Self-timed operation timer: counts a loaded number of cycles
`timescale 1ns/1ps
module sfsp_optimer #(
  parameter W = 32
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         start_i,
  input  wire [W-1:0] cycles_i,
  output wire         running_o,
  output reg          done_o
);

  reg [W-1:0] cnt_r;
  reg         run_r;

  // Load on start, count down, pulse done on the last cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= {W{1'b0}};
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !run_r)
      begin
        cnt_r <= cycles_i;
        run_r <= 1'b1;
      end
      else if (run_r)
      begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
        begin
          run_r  <= 1'b0;
          done_o <= 1'b1;
        end
        else
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign running_o = run_r;

endmodule

// ### rtl/sfsp_top.v
// Serial flash control side: status byte, protect, reset, busy, SPI mode
`timescale 1ns/1ps
`include "sfsp_regs.vh"
module sfsp_top #(
  parameter [31:0] XFR_CYCLES   = `SFSP_T_XFR_TYP_US * `SFSP_CLK_MHZ,
  parameter [31:0] EP_CYCLES    = `SFSP_T_EP_TYP_MS * 1000 * `SFSP_CLK_MHZ,
  parameter [31:0] P_CYCLES     = `SFSP_T_P_TYP_MS * 1000 * `SFSP_CLK_MHZ,
  parameter [2:0]  DENSITY_CODE = 3'h2 // Arbitrary value
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        cs_n_i,
  input  wire        sck_i,
  input  wire        si_i,
  input  wire        wp_n_i,
  input  wire        rst_n_i,
  input  wire        cmp_mismatch_i,
  output wire        so_o,
  output wire        so_oe_n_o,
  output wire        rdy_busy_o,
  output wire        rdy_busy_oe_n_o,
  output wire [7:0]  device_status_byte_o,
  output wire        mode3_o,
  output wire        array_busy_o,
  output wire [1:0]  buf_locked_o,
  output reg         op_start_o,
  output reg  [2:0]  op_kind_o,
  output reg         op_buf_o,
  output reg  [11:0] op_page_o,
  output wire        op_done_o
);

  // Operation state machine
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // Decode opcode into {buffer, kind}
  function [3:0] op_decode;
    input [7:0] op;
    begin
      case (op)
        `SFSP_OP_XFR_B1:  op_decode = {1'b0, `SFSP_KIND_XFR};
        `SFSP_OP_XFR_B2:  op_decode = {1'b1, `SFSP_KIND_XFR};
        `SFSP_OP_CMP_B1:  op_decode = {1'b0, `SFSP_KIND_CMP};
        `SFSP_OP_CMP_B2:  op_decode = {1'b1, `SFSP_KIND_CMP};
        `SFSP_OP_EPRG_B1: op_decode = {1'b0, `SFSP_KIND_EPRG};
        `SFSP_OP_EPRG_B2: op_decode = {1'b1, `SFSP_KIND_EPRG};
        `SFSP_OP_MPRG_B1: op_decode = {1'b0, `SFSP_KIND_EPRG};
        `SFSP_OP_MPRG_B2: op_decode = {1'b1, `SFSP_KIND_EPRG};
        `SFSP_OP_PRG_B1:  op_decode = {1'b0, `SFSP_KIND_PRG};
        `SFSP_OP_PRG_B2:  op_decode = {1'b1, `SFSP_KIND_PRG};
        `SFSP_OP_RWR_B1:  op_decode = {1'b0, `SFSP_KIND_RWR};
        `SFSP_OP_RWR_B2:  op_decode = {1'b1, `SFSP_KIND_RWR};
        default:          op_decode = {1'b0, `SFSP_KIND_NONE};
      endcase
    end
  endfunction

  // Pin synchronisers, order {rst_n, wp_n, si, sck, cs_n}
  wire [4:0] pin_raw = {rst_n_i, wp_n_i, si_i, sck_i, cs_n_i};
  reg  [4:0] sync1_r;
  reg  [4:0] sync2_r;

  // Two flops per pin; idle high so open pins read as pulled up
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_r <= 5'h1f;
      sync2_r <= 5'h1f;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  wire cs_n  = sync2_r[0];
  wire sck   = sync2_r[1];
  wire si    = sync2_r[2];
  wire wp_n  = sync2_r[3];
  // Power-on reset plus device reset pin held low
  wire rst_int = srst_i | ~sync2_r[4];

  reg cs_d_r;
  reg sck_d_r;

  // Edge history of chip select and serial clock
  always @(posedge clk_i)
  begin
    if (rst_int)
    begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b1;
    end
    else
    begin
      cs_d_r  <= cs_n;
      sck_d_r <= sck;
    end
  end

  wire cs_fall  = cs_d_r & ~cs_n;
  wire cs_rise  = ~cs_d_r & cs_n;
  wire sck_rise = ~sck_d_r & sck & ~cs_n & ~cs_d_r;
  wire sck_fall = sck_d_r & ~sck & ~cs_n & ~cs_d_r;

  reg         mode3_r;
  reg         selected_r;
  reg  [31:0] cmd_sr_r;
  reg  [5:0]  bit_cnt_r;
  reg         stat_rd_r;
  reg  [2:0]  stat_idx_r;
  reg         so_r;
  reg         so_drv_r;
  reg         state_r;
  reg         cmp_r;

  wire [7:0] status_byte = {(state_r == ST_IDLE), cmp_r, DENSITY_CODE,
                            `SFSP_STAT_RSVD};
  wire [7:0] next_op = {cmd_sr_r[6:0], si};

  // Command decode at chip select rise
  wire [3:0]  dec      = op_decode(cmd_sr_r[31:24]);
  wire [11:0] page     = cmd_sr_r[`SFSP_PA_MSB:`SFSP_PA_LSB];
  wire        is_prog  = (dec[2:0] == `SFSP_KIND_EPRG) ||
                         (dec[2:0] == `SFSP_KIND_PRG) ||
                         (dec[2:0] == `SFSP_KIND_RWR);
  wire        protect  = ~wp_n && is_prog &&
                         (page[11:8] == `SFSP_PROT_PAGE_HI);
  wire        launch   = cs_rise && selected_r &&
                         (bit_cnt_r == `SFSP_CMD_BITS) &&
                         (dec[2:0] != `SFSP_KIND_NONE) &&
                         (state_r == ST_IDLE) && !protect;

  // Serial framing, mode pick and status shifting
  always @(posedge clk_i)
  begin
    if (rst_int)
    begin
      mode3_r    <= 1'b1;
      selected_r <= 1'b0;
      cmd_sr_r   <= 32'h0000_0000;
      bit_cnt_r  <= 6'd0;
      stat_rd_r  <= 1'b0;
      stat_idx_r <= 3'd0;
      so_r       <= 1'b0;
      so_drv_r   <= 1'b0;
    end
    else if (cs_n)
    begin
      bit_cnt_r <= 6'd0;
      stat_rd_r <= 1'b0;
      so_drv_r  <= 1'b0;
    end
    else if (cs_fall)
    begin
      mode3_r    <= sck;
      selected_r <= 1'b1;
      bit_cnt_r  <= 6'd0;
    end
    else
    begin
      // Input bits taken on rising clock edges only
      if (sck_rise && bit_cnt_r != `SFSP_CMD_BITS)
      begin
        cmd_sr_r  <= {cmd_sr_r[30:0], si};
        bit_cnt_r <= bit_cnt_r + 6'd1;
        if (bit_cnt_r == 6'd7 && next_op == `SFSP_OP_STATUS_READ)
        begin
          stat_rd_r  <= 1'b1;
          stat_idx_r <= 3'd0;
        end
      end
      // Status bits leave on falling edges, MSB first, wrapping
      if (sck_fall && stat_rd_r)
      begin
        so_r       <= status_byte[3'd7 - stat_idx_r];
        so_drv_r   <= 1'b1;
        stat_idx_r <= stat_idx_r + 3'd1;
      end
    end
  end

  // Duration of the launched operation
  reg [31:0] op_cycles;
  always @*
  begin
    case (dec[2:0])
      `SFSP_KIND_XFR: op_cycles = XFR_CYCLES;
      `SFSP_KIND_CMP: op_cycles = XFR_CYCLES;
      `SFSP_KIND_PRG: op_cycles = P_CYCLES;
      default:        op_cycles = EP_CYCLES;
    endcase
  end

  wire tmr_run;
  wire tmr_done;

  sfsp_optimer #(
    .W (32)
  ) u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_int),
    .start_i   (launch),
    .cycles_i  (op_cycles),
    .running_o (tmr_run),
    .done_o    (tmr_done)
  );

  // Idle and busy sequencing; reset drops any operation
  always @(posedge clk_i)
  begin
    if (rst_int)
    begin
      state_r    <= ST_IDLE;
      cmp_r      <= `SFSP_COMP_RESET;
      op_start_o <= 1'b0;
      op_kind_o  <= `SFSP_KIND_NONE;
      op_buf_o   <= 1'b0;
      op_page_o  <= 12'h000;
    end
    else
    begin
      op_start_o <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (launch)
          begin
            state_r    <= ST_BUSY;
            op_start_o <= 1'b1;
            op_kind_o  <= dec[2:0];
            op_buf_o   <= dec[3];
            op_page_o  <= page;
          end
        ST_BUSY:
          if (tmr_done)
          begin
            state_r <= ST_IDLE;
            if (op_kind_o == `SFSP_KIND_CMP)
              cmp_r <= cmp_mismatch_i;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Pin and status outputs
  assign so_o                 = so_r;
  assign so_oe_n_o            = ~so_drv_r;
  assign rdy_busy_o           = 1'b0;
  assign rdy_busy_oe_n_o      = ~state_r;
  assign device_status_byte_o = status_byte;
  assign mode3_o              = mode3_r;
  assign array_busy_o         = state_r;
  assign buf_locked_o         = state_r ? {op_buf_o, ~op_buf_o}
                                        : 2'b00;
  assign op_done_o            = tmr_done;

endmodule

// ### sim/sfsp_props.sv
// Checker for the flash control block
`timescale 1ns/1ps
module sfsp_props #(
  parameter [2:0] DENSITY_CODE = 3'h2
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        cs_n_i,
  input  wire        rst_n_i,
  input  wire        wp_n_i,
  input  wire        so_oe_n_o,
  input  wire        rdy_busy_oe_n_o,
  input  wire [7:0]  device_status_byte_o,
  input  wire        mode3_o,
  input  wire        array_busy_o,
  input  wire [1:0]  buf_locked_o,
  input  wire        op_start_o,
  input  wire [2:0]  op_kind_o,
  input  wire        op_buf_o,
  input  wire [11:0] op_page_o,
  input  wire        op_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Chip select seen idle, pin reset seen held
  sequence cs_idle_s;
    cs_n_i [*6];
  endsequence
  sequence pin_rst_s;
    !rst_n_i [*4];
  endsequence
  // Status, busy pin and timed operation relations
  ready_bit_a: assert property (
    device_status_byte_o[7] != array_busy_o)
    else $error("ready bit mismatch");
  fixed_bits_a: assert property (
    device_status_byte_o[5:0] == {DENSITY_CODE, 3'h0})
    else $error("density bits wrong");
  busy_pin_a: assert property (
    rdy_busy_oe_n_o != array_busy_o)
    else $error("busy pin mismatch");
  start_cs_a: assert property (
    op_start_o |-> cs_n_i && array_busy_o)
    else $error("start without busy");
  done_idle_a: assert property (
    op_done_o |=> !array_busy_o && rdy_busy_oe_n_o)
    else $error("busy after done");
  so_release_a: assert property (
    cs_idle_s |-> so_oe_n_o)
    else $error("serial out driven while idle");
  wp_guard_a: assert property (
    op_start_o && op_kind_o >= 3'd3 && op_page_o[11:8] == 4'h0
    |-> wp_n_i)
    else $error("protected page programmed");
  pin_reset_a: assert property (
    pin_rst_s |-> !array_busy_o && so_oe_n_o && mode3_o)
    else $error("pin reset not idle");
  lock_one_a: assert property (
    array_busy_o && $past(array_busy_o)
    |-> $stable(op_buf_o) &&
        buf_locked_o == (op_buf_o ? 2'b10 : 2'b01))
    else $error("wrong buffer locked");
endmodule
bind sfsp_top sfsp_props #(.DENSITY_CODE(DENSITY_CODE)) u_props (
  .clk_i                (clk_i),
  .srst_i               (srst_i),
  .cs_n_i               (cs_n_i),
  .rst_n_i              (rst_n_i),
  .wp_n_i               (wp_n_i),
  .so_oe_n_o            (so_oe_n_o),
  .rdy_busy_oe_n_o      (rdy_busy_oe_n_o),
  .device_status_byte_o (device_status_byte_o),
  .mode3_o              (mode3_o),
  .array_busy_o         (array_busy_o),
  .buf_locked_o         (buf_locked_o),
  .op_start_o           (op_start_o),
  .op_kind_o            (op_kind_o),
  .op_buf_o             (op_buf_o),
  .op_page_o            (op_page_o),
  .op_done_o            (op_done_o)
);

// ### sim/sfsp_host.sv
// Host SPI master model for the flash control pins
`timescale 1ns/1ps
module sfsp_host (
  input  wire clk_i,
  input  wire so_i,
  input  wire so_oe_n_i,
  output reg  cs_n_o,
  output reg  sck_o,
  output reg  si_o
);
  reg [15:0] rd_q;
  integer    i;
  // Idle pins at time zero
  initial
  begin
    cs_n_o = 1'b1;
    sck_o  = 1'b1;
    si_o   = 1'b0;
    rd_q   = 16'h0000;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // One frame: nb bits out MSB first, then nr bits read back
  task xfer(input [31:0] w, input integer nb, input integer nr,
            input m3);
    begin
      tick(1);
      sck_o <= m3;
      tick(64);
      cs_n_o <= 1'b0;
      tick(4);
      for (i = 0; i < nb + nr; i = i + 1)
      begin
        sck_o <= 1'b0;
        si_o  <= (i < nb) ? w[31-i] : ~si_o;
        tick(4);
        sck_o <= 1'b1;
        tick(2);
        rd_q = {rd_q[14:0], so_oe_n_i ? ~rd_q[0] : so_i};
        tick(2);
      end
      sck_o <= m3;
      tick(4);
      cs_n_o <= 1'b1;
      si_o   <= ~si_o;
    end
  endtask
endmodule

// ### sim/test_serial_flash_status_protect_reset.sv
// Bench for the flash control block
`timescale 1ns/1ps
module test_serial_flash_status_protect_reset;
  localparam [2:0] DENS = 3'h5; // Arbitrary density code
  localparam [7:0] IDLE = {2'b10, DENS, 3'h0};
  // Busy pin released, ready set, density and reserved bits
  localparam [7:0] DONE_EXP = {2'b11, DENS, 3'h0};
  reg        clk_i, srst_i, wp_n_i, rst_n_i, cmp_i;
  wire       cs_n, sck, si, so, so_oe_n, rb, rb_oe_n, m3;
  wire       abusy, start, opbuf, done;
  wire [7:0] stat;
  wire [1:0] lock;
  wire [2:0] kind;
  wire [11:0] page;
  integer    error_cnt, checks, n;
  wire       pin_rb = rb_oe_n ? 1'b1 : rb; // Pull-up on busy pin
  sfsp_top #(.XFR_CYCLES(1500), .EP_CYCLES(800), .P_CYCLES(600),
    .DENSITY_CODE(DENS)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .wp_n_i(wp_n_i), .rst_n_i(rst_n_i),
    .cmp_mismatch_i(cmp_i), .so_o(so), .so_oe_n_o(so_oe_n),
    .rdy_busy_o(rb), .rdy_busy_oe_n_o(rb_oe_n),
    .device_status_byte_o(stat), .mode3_o(m3),
    .array_busy_o(abusy), .buf_locked_o(lock), .op_start_o(start),
    .op_kind_o(kind), .op_buf_o(opbuf), .op_page_o(page),
    .op_done_o(done));
  sfsp_host host (.clk_i(clk_i), .so_i(so), .so_oe_n_i(so_oe_n),
    .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  function [31:0] w(input [7:0] op, input [11:0] pg);
    w = {op, 3'h0, pg, 9'h000};
  endfunction
  task chk(input string nm, input [23:0] exp, input [23:0] got);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        $display("[ERR] %s exp %h got %h", nm, exp, got);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Look for a launch within 50 clocks of chip select rising
  task wait_start(input exp);
    begin
      n = 0;
      while (start !== 1'b1 && n < 50)
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      chk("op start", exp, n < 50);
      if (exp)
        chk("busy pin", 0, {pin_rb, stat[7]});
    end
  endtask
  task wait_done;
    begin
      n = 0;
      while (done !== 1'b1 && n < 3000)
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (n == 3000)
      begin
        error_cnt = error_cnt + 1;
        tally_and_finish;
      end
      else
      begin
        @(negedge clk_i);
        chk("idle", DONE_EXP, {pin_rb, stat[7], stat[5:0]});
        @(posedge clk_i);
      end
    end
  endtask
  task t_reset;
    begin
      chk("status", IDLE, stat);
      chk("pins", 3'b111, {m3, so_oe_n, pin_rb});
    end
  endtask
  task t_status;
    begin
      host.xfer(w(8'h57, 0), 8, 16, 1'b0);
      chk("status rd", {IDLE, IDLE}, host.rd_q);
      chk("mode", 0, m3);
      host.xfer(w(8'h57, 0), 8, 8, 1'b1);
      chk("mode", 1, m3);
    end
  endtask
  task t_xfr;
    begin
      host.xfer(w(8'h53, 12'h005), 32, 0, 1'b1);
      wait_start(1);
      chk("op", {2'b01, 3'd1, 12'h005}, {lock, kind, page});
      host.xfer(w(8'h57, 0), 8, 8, 1'b1);
      chk("busy rd", 0, host.rd_q[7]);
      host.xfer(w(8'h55, 12'h005), 32, 0, 1'b1);
      wait_start(0);
      wait_done;
    end
  endtask
  task t_cmp;
    begin
      cmp_i <= 1'b1;
      host.xfer(w(8'h61, 12'h010), 32, 0, 1'b0);
      wait_start(1);
      chk("lock", 2'b10, lock);
      wait_done;
      chk("comp", 1, stat[6]);
      @(posedge clk_i);
      cmp_i <= 1'b0;
      host.xfer(w(8'h60, 12'h010), 32, 0, 1'b1);
      wait_start(1);
      wait_done;
      chk("comp", 0, stat[6]);
    end
  endtask
  task t_prot;
    begin
      wp_n_i <= 1'b0;
      host.xfer(w(8'h83, 12'h0FF), 32, 0, 1'b1);
      wait_start(0);
      host.xfer(w(8'h85, 12'h080), 32, 0, 1'b0);
      wait_start(0);
      host.xfer(w(8'h89, 12'h100), 32, 0, 1'b1);
      wait_start(1);
      wait_done;
      @(posedge clk_i);
      wp_n_i <= 1'b1;
      host.xfer(w(8'h88, 12'h000), 32, 0, 1'b1);
      wait_start(1);
      wait_done;
    end
  endtask
  task t_pin_rst;
    begin
      host.xfer(w(8'h57, 0), 8, 8, 1'b0);
      host.xfer(w(8'h58, 12'h003), 32, 0, 1'b1);
      wait_start(1);
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk("reset", 4'b0111, {abusy, pin_rb, m3, so_oe_n});
      rst_n_i <= 1'b1;
      host.xfer(w(8'h57, 0), 8, 8, 1'b1);
      chk("resume", IDLE, host.rd_q[7:0]);
    end
  endtask
  // Core clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Main sequence
  initial
  begin
    error_cnt = 0;
    checks    = 0;
    srst_i    = 1'b1;
    wp_n_i    = 1'b1;
    rst_n_i   = 1'b1;
    cmp_i     = 1'b0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset;
    t_status;
    t_xfr;
    t_cmp;
    t_prot;
    t_pin_rst;
    tally_and_finish;
  end
endmodule
